// ---- ldisp_i2c_master.sv ----
// Purpose: Bus master model driving SCL and pulling SDA low.
// Assumes: Eight CLOCK cycles per bit, SDA pulled up when released.
// Notes:   SCL stands high between frames.
`timescale 1ns/1ps
module ldisp_i2c_master (
  input wire logic CLOCK,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  // Idle bus, both lines released
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // Quarter bit time
  task automatic q();
    repeat (2) @(posedge CLOCK);
  endtask

  task automatic start();
    q();
    sda_oe <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_oe <= 1'b1;
    q();
    scl <= 1'b0;
  endtask

  task automatic stop();
    q();
    sda_oe <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_oe <= 1'b0;
    q();
  endtask

  // One bit: data set while SCL low, sampled mid high
  task automatic bt(input logic b, output logic s);
    q();
    sda_oe <= !b;
    q();
    scl <= 1'b1;
    q();
    @(negedge CLOCK);
    s = sda;
    q();
    scl <= 1'b0;
  endtask

  // byte then ack slot, nack ends a read
  task automatic xb(input logic [7:0] w, input logic mack, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bt(w[i], r[i]);
    bt(!mack, s);
    ack = !s;
  endtask
endmodule

// ---- ldisp_pkg.sv ----
// Purpose: Shared constants and types of the LED driver bus slave front end.
// Assumes: 7-bit bus addresses, 5-bit register pointer.
// Notes:   Address bytes are kept in 8-bit form with the direction bit at 0.
package ldisp_pkg;

  // ************************************************************
  // Byte framing
  // ************************************************************
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam int MSB = 7;
  localparam int RW_BIT = 0;
  localparam logic RW_READ = 1'b1;

  // ************************************************************
  // Pointer-control byte layout
  // ************************************************************
  localparam int PTR_W = 5;
  localparam int OPT_LSB = 5;
  localparam int OPT_MSB = 7;
  localparam int INCR_EN_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] OPT_ALL = 2'h0;
  localparam logic [1:0] OPT_BRIGHT = 2'h1;
  localparam logic [1:0] OPT_GROUP = 2'h2;
  localparam logic [1:0] OPT_BOTH = 2'h3;

  // ************************************************************
  // Pointer windows
  // ************************************************************
  localparam logic [4:0] PTR_FIRST = 5'h00;
  localparam logic [4:0] PTR_LAST = 5'h1B;
  localparam logic [4:0] PTR_ONE = 5'h01;
  localparam logic [4:0] BRIGHT_FIRST = 5'h02;
  localparam logic [4:0] BRIGHT_LAST = 5'h11;
  localparam logic [4:0] GROUP_FIRST = 5'h12;
  localparam logic [4:0] GROUP_LAST = 5'h13;

  // ************************************************************
  // Internal register offsets and reset values
  // ************************************************************
  localparam logic [4:0] OFS_FIRST_MODE = 5'h00;
  localparam logic [4:0] OFS_SUB1 = 5'h18;
  localparam logic [4:0] OFS_SUB2 = 5'h19;
  localparam logic [4:0] OFS_SUB3 = 5'h1A;
  localparam logic [4:0] OFS_GROUP = 5'h1B;
  localparam int GCE_BIT = 0;
  localparam int SUB1_EN_BIT = 3;
  localparam int SUB2_EN_BIT = 2;
  localparam int SUB3_EN_BIT = 1;
  localparam logic [7:0] FIRST_MODE_RESET = 8'h01;
  localparam logic [7:0] GROUP_RESET = 8'hD0;
  localparam logic [7:0] SUB1_RESET = 8'hD2;
  localparam logic [7:0] SUB2_RESET = 8'hD4;
  localparam logic [7:0] SUB3_RESET = 8'hD8;
  localparam logic [7:0] ADDR_LSB_MASK = 8'hFE;
  // Software-reset call address, value is arbitrary
  localparam logic [6:0] SOFT_RESET_ADDR = 7'h5A;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK_OUT, ST_TX, ST_ACK_IN} ldisp_state_t;
  typedef enum logic [1:0] {K_ADDR, K_CTRL, K_DATA, K_SWR} ldisp_kind_t;

endpackage

// ---- ldisp_ptr_step.sv ----
// Purpose: Next register pointer after one data byte.
// Assumes: Option field is the three high bits of the pointer-control byte.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module ldisp_ptr_step
  import ldisp_pkg::*;
(
  input wire logic [4:0] ptr,
  input wire logic [2:0] opt,
  output logic [4:0] nxt
);

  logic [4:0] linear;
  logic [4:0] windowed;

  // Full-range count, wrapping after the last register
  // wrap after last register
  assign linear = (ptr == PTR_LAST) ? PTR_FIRST : ptr + PTR_ONE;

  // Window rollover selected by the two option bits
  always_comb begin
    windowed = linear;
    unique case (opt[1:0])
      OPT_ALL: windowed = linear;
      OPT_BRIGHT: windowed = (ptr == BRIGHT_LAST) ? BRIGHT_FIRST : linear;
      OPT_GROUP: windowed = (ptr == GROUP_LAST) ? GROUP_FIRST : linear;
      OPT_BOTH: windowed = (ptr == GROUP_LAST) ? BRIGHT_FIRST : linear;
    endcase
  end

  assign nxt = opt[INCR_EN_BIT] ? windowed : ptr;

endmodule

// ---- ldisp_slave.sv ----
// Purpose: Bus slave front end with address decode and register pointer.
// Assumes: SCL and SDA are oversampled by CLOCK, at least 8 clocks per SCL period.
// Notes:   The register bank outside reads combinationally from REG_RADDR.
`timescale 1ns/1ps
module ldisp_slave
  import ldisp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic [6:0] DEV_ADDR,
  output logic [4:0] REG_RADDR,
  input wire logic [7:0] REG_RDATA,
  output logic REG_RD,
  output logic [4:0] REG_WADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WR,
  output logic [2:0] INCR_OPTION,
  output logic SOFT_RESET_CALL,
  output logic BUSY
);

  // ************************************************************
  // Address match helper
  // ************************************************************
  function automatic logic addr_hit(input logic [6:0] a, input logic [7:0] r, input logic en);
    addr_hit = en && (a == r[MSB:1]);
  endfunction

  // ************************************************************
  // Pin synchronisation and bus conditions
  // ************************************************************
  logic [8:0] pins_s;
  logic scl_s, sda_s;
  logic [6:0] dev_s;
  logic scl_prev_q, sda_prev_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  ldisp_sync #(.W(9)) u_sync (
    .CLOCK(CLOCK),
    .RESETN(RESETN),
    .D({DEV_ADDR, SDA_IN, SCL}),
    .Q(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign dev_s = pins_s[8:2];

  // Previous samples for edge detection
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ************************************************************
  // State and held registers
  // ************************************************************
  ldisp_state_t state_q;
  ldisp_kind_t kind_q;
  ldisp_kind_t next_kind_q;
  logic next_tx_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ctrl_q;
  logic [7:0] first_mode_q;
  logic [7:0] group_q;
  logic [7:0] sub_q [3];
  logic sda_oe_q, sda_out_q;
  logic reg_rd_q, reg_wr_q;
  logic [4:0] reg_waddr_q;
  logic [7:0] reg_wdata_q;
  logic soft_q;
  logic busy_q;

  // ************************************************************
  // Byte decode
  // ************************************************************
  logic [4:0] ptr;
  logic [4:0] ptr_nxt;
  logic [6:0] addr7;
  logic is_read;
  logic hit_dev, hit_group, hit_sub, hit_soft, addr_ack;
  logic byte_done, data_wr, load_tx;
  logic [7:0] rd_byte;

  assign ptr = ctrl_q[PTR_W-1:0];
  assign addr7 = shift_q[MSB:1];
  assign is_read = (shift_q[RW_BIT] == RW_READ);
  assign hit_dev = (addr7 == dev_s);
  assign hit_group = addr_hit(addr7, group_q, first_mode_q[GCE_BIT]);
  // sub calls gated by their enables
  assign hit_sub = addr_hit(addr7, sub_q[0], first_mode_q[SUB1_EN_BIT]) |
                   addr_hit(addr7, sub_q[1], first_mode_q[SUB2_EN_BIT]) |
                   addr_hit(addr7, sub_q[2], first_mode_q[SUB3_EN_BIT]);
  assign hit_soft = (addr7 == SOFT_RESET_ADDR) & ~is_read;
  assign addr_ack = hit_dev | hit_group | hit_sub | hit_soft;
  assign byte_done = (state_q == ST_RX) & scl_fall & (cnt_q == BYTE_BITS);
  assign data_wr = byte_done & (kind_q == K_DATA);
  // Next transmit byte is loaded at the falling edge ending an acknowledge
  assign load_tx = scl_fall & (((state_q == ST_ACK_OUT) & next_tx_q) |
                               ((state_q == ST_ACK_IN) & ~sda_oe_q & (cnt_q == CNT_ONE)));

  // group address reads with bit 0 clear
  assign rd_byte = (ptr == OFS_FIRST_MODE) ? first_mode_q :
                   (ptr == OFS_SUB1) ? sub_q[0] :
                   (ptr == OFS_SUB2) ? sub_q[1] :
                   (ptr == OFS_SUB3) ? sub_q[2] :
                   (ptr == OFS_GROUP) ? group_q : REG_RDATA;

  ldisp_ptr_step u_step (
    .ptr(ptr),
    .opt(ctrl_q[OPT_MSB:OPT_LSB]),
    .nxt(ptr_nxt)
  );

  // ************************************************************
  // Bus state machine
  // ************************************************************
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_IDLE;
      kind_q <= K_ADDR;
      next_kind_q <= K_ADDR;
      next_tx_q <= 1'b0;
      cnt_q <= CNT_ZERO;
      shift_q <= CTRL_RESET;
      sda_oe_q <= 1'b0;
    end else if (bus_start) begin
      state_q <= ST_RX;
      kind_q <= K_ADDR;
      cnt_q <= CNT_ZERO;
      sda_oe_q <= 1'b0;
    end else if (bus_stop) begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_q <= {shift_q[MSB-1:0], sda_s};
            cnt_q <= cnt_q + CNT_ONE;
          end else if (byte_done) begin
            state_q <= ST_ACK_OUT;
            sda_oe_q <= 1'b1;
            next_tx_q <= 1'b0;
            unique case (kind_q)
              K_ADDR: begin
                if (!addr_ack) begin
                  state_q <= ST_IDLE;
                  sda_oe_q <= 1'b0;
                end
                next_tx_q <= is_read & ~hit_soft;
                // next written byte is pointer control, except after the soft-reset call
                next_kind_q <= hit_soft ? K_SWR : K_CTRL;
              end
              K_CTRL: next_kind_q <= K_DATA;
              K_DATA: next_kind_q <= K_DATA;
              K_SWR: next_kind_q <= K_SWR;
            endcase
          end
        end
        ST_ACK_OUT: begin
          if (scl_fall) begin
            kind_q <= next_kind_q;
            cnt_q <= CNT_ZERO;
            if (next_tx_q) begin
              state_q <= ST_TX;
              shift_q <= {rd_byte[MSB-1:0], 1'b0};
              sda_oe_q <= ~rd_byte[MSB];
            end else begin
              state_q <= ST_RX;
              sda_oe_q <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            cnt_q <= cnt_q + CNT_ONE;
            if (cnt_q == BYTE_BITS - CNT_ONE) begin
              state_q <= ST_ACK_IN;
              cnt_q <= CNT_ZERO;
              sda_oe_q <= 1'b0;
            end else begin
              shift_q <= {shift_q[MSB-1:0], 1'b0};
              sda_oe_q <= ~shift_q[MSB];
            end
          end
        end
        ST_ACK_IN: begin
          // Count 1 marks a master acknowledge seen on the rising edge
          if (scl_rise) begin
            cnt_q <= sda_s ? CNT_ZERO : CNT_ONE;
          end else if (load_tx) begin
            state_q <= ST_TX;
            cnt_q <= CNT_ZERO;
            shift_q <= {rd_byte[MSB-1:0], 1'b0};
            sda_oe_q <= ~rd_byte[MSB];
          end else if (scl_fall) begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Pointer-control byte
  // ************************************************************
  // held across transactions, reset only by RESETN
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q <= CTRL_RESET;
    end else if (byte_done && kind_q == K_CTRL) begin
      // any start pointer taken as is
      ctrl_q <= shift_q;
    end else if (data_wr || load_tx) begin
      ctrl_q <= {ctrl_q[OPT_MSB:OPT_LSB], ptr_nxt};
    end
  end

  // ************************************************************
  // Internal address registers
  // ************************************************************
  // group call enabled at D0
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      first_mode_q <= FIRST_MODE_RESET;
      group_q <= GROUP_RESET;
      sub_q[0] <= SUB1_RESET;
      sub_q[1] <= SUB2_RESET;
      sub_q[2] <= SUB3_RESET;
    end else if (data_wr) begin
      if (ptr == OFS_FIRST_MODE) first_mode_q <= shift_q;
      if (ptr == OFS_SUB1) sub_q[0] <= shift_q & ADDR_LSB_MASK;
      if (ptr == OFS_SUB2) sub_q[1] <= shift_q & ADDR_LSB_MASK;
      if (ptr == OFS_SUB3) sub_q[2] <= shift_q & ADDR_LSB_MASK;
      if (ptr == OFS_GROUP) group_q <= shift_q & ADDR_LSB_MASK;
    end
  end

  // ************************************************************
  // User-side strobes and outputs
  // ************************************************************
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_waddr_q <= PTR_FIRST;
      reg_wdata_q <= CTRL_RESET;
      soft_q <= 1'b0;
      busy_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      reg_wr_q <= data_wr;
      reg_rd_q <= load_tx;
      if (data_wr) begin
        reg_waddr_q <= ptr;
        reg_wdata_q <= shift_q;
      end
      soft_q <= byte_done & (kind_q == K_ADDR) & hit_soft;
      busy_q <= (state_q != ST_IDLE);
      sda_out_q <= 1'b0; // Open drain, only ever pulls low
    end
  end

  assign SDA_OUT = sda_out_q;
  assign SDA_OE = sda_oe_q;
  assign REG_RADDR = ctrl_q[PTR_W-1:0];
  assign REG_RD = reg_rd_q;
  assign REG_WADDR = reg_waddr_q;
  assign REG_WDATA = reg_wdata_q;
  assign REG_WR = reg_wr_q;
  assign INCR_OPTION = ctrl_q[OPT_MSB:OPT_LSB];
  assign SOFT_RESET_CALL = soft_q;
  assign BUSY = busy_q;

endmodule

// ---- ldisp_slave_sva.sv ----
// Purpose: Checker of pointer stepping and acknowledge at the slave ports.
// Assumes: Pointer moves on the edge that raises the write or read strobe.
// Notes:   Bound to every ldisp_slave instance.
`timescale 1ns/1ps
module ldisp_slave_sva (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic SDA_OE,
  input wire logic [4:0] REG_RADDR,
  input wire logic REG_RD,
  input wire logic [4:0] REG_WADDR,
  input wire logic REG_WR,
  input wire logic [2:0] INCR_OPTION
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  // Expected pointer after a byte at REG_WADDR
  wire logic [4:0] inc_nxt = (REG_WADDR == 5'h1B) ? 5'h00 : REG_WADDR + 5'h01;
  wire logic [4:0] exp_nxt = (INCR_OPTION[1:0] == 2'h1 && REG_WADDR == 5'h11) ? 5'h02 :
    (INCR_OPTION[1] && REG_WADDR == 5'h13) ? {~INCR_OPTION[0], 4'h2} : inc_nxt;

  property p_wr_addr; REG_WR |-> REG_WADDR == $past(REG_RADDR); endproperty
  a_wr_addr: assert property (p_wr_addr)
    else $error("write address is not the old pointer");
  property p_hold; REG_WR && !INCR_OPTION[2] |-> REG_RADDR == REG_WADDR; endproperty
  a_hold: assert property (p_hold)
    else $error("pointer moved without increment");
  property p_all; REG_WR && INCR_OPTION == 3'h4 |-> REG_RADDR == exp_nxt; endproperty
  a_all: assert property (p_all)
    else $error("wrong step in full window");
  property p_bright; REG_WR && INCR_OPTION == 3'h5 |-> REG_RADDR == exp_nxt; endproperty
  a_bright: assert property (p_bright)
    else $error("wrong step in brightness window");
  property p_group; REG_WR && INCR_OPTION == 3'h6 |-> REG_RADDR == exp_nxt; endproperty
  a_group: assert property (p_group)
    else $error("wrong step in group window");
  property p_both; REG_WR && INCR_OPTION == 3'h7 |-> REG_RADDR == exp_nxt; endproperty
  a_both: assert property (p_both)
    else $error("wrong step in joint window");
  property p_rd_adv; REG_RD && INCR_OPTION[2] |-> REG_RADDR != $past(REG_RADDR); endproperty
  a_rd_adv: assert property (p_rd_adv)
    else $error("pointer still after read byte");
  property p_ack_wr; REG_WR |-> SDA_OE ##1 SDA_OE[*3]; endproperty
  a_ack_wr: assert property (p_ack_wr)
    else $error("written byte not acknowledged");
endmodule

bind ldisp_slave ldisp_slave_sva chk_i (.CLOCK(CLOCK), .RESETN(RESETN), .SDA_OE(SDA_OE),
  .REG_RADDR(REG_RADDR), .REG_RD(REG_RD), .REG_WADDR(REG_WADDR), .REG_WR(REG_WR),
  .INCR_OPTION(INCR_OPTION));

// ---- ldisp_sync.sv ----
// Purpose: Two-flop synchroniser for pins entering the CLOCK domain.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
module ldisp_sync #(
  parameter int W = 9
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);

  logic [W-1:0] meta_q;

  // Two stages, first read only by the second
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      meta_q <= '1;
      Q <= '1;
    end else begin
      meta_q <= D;
      Q <= meta_q;
    end
  end

endmodule

// ---- test_ldisp_slave.sv ----
// Purpose: Self-checking bench of the bus slave front end.
// Assumes: Device address 21, bank data is the pointer over 101.
// Notes:   Register writes are matched in order against a queue.
`timescale 1ns/1ps
module test_ldisp_slave;
  import ldisp_pkg::*;
  logic CLOCK = 1'b0;
  logic RESETN = 1'b0;
  // device address clear of call addresses
  logic [6:0] DEV_ADDR = 7'h21;
  logic scl, m_oe, sda, SDA_OUT, SDA_OE, REG_RD, REG_WR, SOFT_RESET_CALL, BUSY;
  logic [4:0] REG_RADDR, REG_WADDR;
  logic [7:0] REG_WDATA, REG_RDATA;
  logic [7:0] mode_val = 8'h01;
  logic [2:0] INCR_OPTION;
  logic [7:0] call_tab [4] = '{8'hD2, 8'hD4, 8'hD8, 8'hD0};
  logic [7:0] at [10] = '{8'h42, 8'h43, 8'hD0, 8'hD1, 8'hD2, 8'hD5, 8'hD8, 8'hB4, 8'hB5, 8'h44};
  logic [9:0] ak = 10'h08F;
  logic [12:0] wq [$];
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int soft_cnt = 0;
  int rd_cnt = 0;

  ldisp_i2c_master m (.CLOCK(CLOCK), .sda(sda), .scl(scl), .sda_oe(m_oe));
  ldisp_slave dut (.CLOCK(CLOCK), .RESETN(RESETN), .SCL(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .DEV_ADDR(DEV_ADDR), .REG_RADDR(REG_RADDR), .REG_RDATA(REG_RDATA),
    .REG_RD(REG_RD), .REG_WADDR(REG_WADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .INCR_OPTION(INCR_OPTION), .SOFT_RESET_CALL(SOFT_RESET_CALL), .BUSY(BUSY));

  always #10 CLOCK = !CLOCK;
  // Open-drain line, pulled up when released
  assign sda = !m_oe && (!SDA_OE || SDA_OUT);
  // Bank answers combinationally from the pointer
  assign REG_RDATA = {REG_RADDR, 3'h5};

  task automatic close_out();
    $display("Compares %0d, errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] s);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // Pointer after one byte
  function automatic logic [4:0] stp(input logic [4:0] p, input logic [2:0] o);
    if (!o[2]) return p;
    if (o[1:0] == 2'h1 && p == 5'h11) return 5'h02;
    if (o[1] && p == 5'h13) return o[0] ? 5'h02 : 5'h12;
    return (p == 5'h1B) ? 5'h00 : p + 5'h01;
  endfunction

  // Address byte and its acknowledge
  task automatic ad(input logic [7:0] x, input logic e, input logic keep);
    logic a;
    logic [7:0] r;
    m.start();
    m.xb(x, 1'b0, r, a);
    chk("addr_ack", {12'h0, e}, {12'h0, a});
    if (a && x[0] && !keep) m.xb(8'hFF, 1'b0, r, a);
    if (!keep) m.stop();
  endtask

  // Control byte then n data bytes
  task automatic wr(input logic [7:0] c, input int n);
    logic a;
    logic [7:0] r, d;
    logic [4:0] p;
    p = c[4:0];
    ad({DEV_ADDR, 1'b0}, 1'b1, 1'b1);
    chk("busy", 13'h1, {12'h0, BUSY});
    m.xb(c, 1'b0, r, a);
    for (int i = 0; i < n; i++) begin
      d = (p == 5'h1B) ? 8'hD1 : (p == 5'h00) ? mode_val : 8'($urandom);
      wq.push_back({p, d});
      p = stp(p, c[7:5]);
      m.xb(d, 1'b0, r, a);
      chk("data_ack", 13'h1, {12'h0, a});
    end
    m.stop();
  endtask

  // Read n bytes from p0, last one not acknowledged
  task automatic rd(input int n, input logic [4:0] p0, input logic [2:0] o);
    logic a;
    logic [7:0] r, e;
    logic [4:0] p;
    p = p0;
    ad({DEV_ADDR, 1'b1}, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      e = (p == 5'h00) ? mode_val : (p >= 5'h18) ? call_tab[2'(p - 5'h18)] : {p, 3'h5};
      m.xb(8'hFF, i < n - 1, r, a);
      chk("rd_data", {5'h0, e}, {5'h0, r});
      p = stp(p, o);
    end
    m.stop();
  endtask

  // Register write monitor
  always @(posedge CLOCK) begin
    if (REG_WR === 1'b1) begin
      if (wq.size() == 0) chk("reg_wr", 13'h0, 13'h1FFF);
      else chk("reg_wr", wq.pop_front(), {REG_WADDR, REG_WDATA});
    end
  end

  // Strobe counters
  always @(posedge CLOCK) begin
    if (SOFT_RESET_CALL === 1'b1) soft_cnt++;
    if (REG_RD === 1'b1) rd_cnt++;
  end

  // Hang limit
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'hF6195046));
    repeat (5) @(posedge CLOCK);
    RESETN <= 1'b1;
    repeat (4) @(posedge CLOCK);
    for (int i = 0; i < 10; i++) ad(at[i], ak[i], 1'b0);
    wr(8'h05, 3);
    wr(8'hB0, 3);
    wr(8'hD2, 3);
    wr(8'hF3, 3);
    wr(8'h9B, 3);
    wr(8'hF4, 0);
    chk("incr_option", 13'h7, {10'h0, INCR_OPTION});
    rd(30, 5'h14, 3'h7);
    mode_val = 8'h08;
    wr(8'h00, 1);
    ad(8'hD0, 1'b0, 1'b0);
    ad(8'hD3, 1'b1, 1'b0);
    repeat (20) @(posedge CLOCK);
    chk("wr_left", 13'h0, 13'(wq.size()));
    chk("soft_calls", 13'h1, 13'(soft_cnt));
    chk("rd_strobes", 13'h21, 13'(rd_cnt));
    chk("busy", 13'h0, {12'h0, BUSY});
    close_out();
  end
endmodule
